// ==== src/ssp_dev.sv ====
// sensor end of the spi register port: serial framing on the link clock,
// register access and command pulses on the system clock
// assumes user logic answers a read request with data one clock later
`timescale 1ns/10ps
module ssp_dev #(
  parameter logic [31:0] FW_REVISION = ssp_pkg::FW_REVISION_DEFAULT
) (
  // system
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // link
  ssp_if.dev link,
  // register read port
  output logic reg_rd_req_out,
  input wire logic [31:0] reg_rd_data_in,
  // register write port
  output logic reg_wr_out,
  output logic reg_wr_nv_out,
  output logic [31:0] reg_wr_data_out,
  output logic [7:0] reg_addr_out,
  // commands
  output logic cmd_out,
  output logic [7:0] cmd_code_out,
  output logic gyro_bias_zeroing_command_out,
  output logic firmware_version_query_out
);

  typedef enum logic [4:0] {
    ST_OP = 5'b00001,
    ST_ADDR = 5'b00010,
    ST_RDATA = 5'b00100,
    ST_WDATA = 5'b01000,
    ST_DEAD = 5'b10000
  } ssp_dev_st_e;

  // link domain, framing state
  ssp_dev_st_e st_r, st_nxt;
  logic [2:0] bit_cnt_r;
  logic [1:0] dcnt_r;
  logic [6:0] rx_r;
  logic op_wr_r;
  logic [7:0] tx_r;
  // link domain, crossing sources (not cleared by deselect)
  logic [7:0] addr_r;
  logic [31:0] wdata_r;
  logic rd_tgl_r;
  logic wr_tgl_r;
  // system domain
  logic [2:0] rd_sync_r;
  logic [2:0] wr_sync_r;
  logic rd_cap_r;
  logic [31:0] rd_data_r;

  // framing is cleared while deselected or in system reset
  wire link_rst = link.ss_n | sys_rst_in; // RL19
  wire [7:0] byte_in = {rx_r, link.mosi}; // RL2
  wire byte_end = (bit_cnt_r == 3'h7);
  wire word_last = (dcnt_r == 2'h3);
  wire is_cmd_addr = (addr_r >= ssp_pkg::ADDR_CMD_BASE); // RL18
  wire new_rd = byte_end & (((st_r == ST_ADDR) & ~op_wr_r) | ((st_r == ST_RDATA) & word_last));
  wire new_wr = byte_end & (st_r == ST_WDATA) & word_last;

  // next framing state, evaluated per byte
  always_comb begin
    st_nxt = st_r;
    if (byte_end) begin
      unique case (st_r)
        ST_OP: begin
          if (byte_in == ssp_pkg::OP_READ || byte_in == ssp_pkg::OP_WRITE) begin // RL5
            st_nxt = ST_ADDR;
          end else begin
            st_nxt = ST_DEAD; // RL20
          end
        end
        ST_ADDR: st_nxt = op_wr_r ? ST_WDATA : ST_RDATA; // RL5
        ST_RDATA: st_nxt = ST_RDATA; // RL8
        ST_WDATA: st_nxt = word_last ? ST_DEAD : ST_WDATA; // RL11
        ST_DEAD: st_nxt = ST_DEAD;
        default: st_nxt = ST_DEAD;
      endcase
    end
  end

  // rising edge: shift mosi in, count bits and bytes
  always_ff @(posedge link.sck or posedge link_rst) begin
    if (link_rst) begin
      st_r <= ST_OP; // RL19
      bit_cnt_r <= 3'h0;
      dcnt_r <= 2'h0;
      rx_r <= 7'h00;
      op_wr_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      bit_cnt_r <= bit_cnt_r + 3'h1;
      rx_r <= byte_in[6:0];
      if (byte_end && st_r == ST_OP) begin
        op_wr_r <= (byte_in == ssp_pkg::OP_WRITE);
      end
      if (byte_end && (st_r == ST_RDATA || st_r == ST_WDATA)) begin
        dcnt_r <= dcnt_r + 2'h1; // RL6 RL9
      end
    end
  end

  // rising edge: address and write word, held for the system side
  always_ff @(posedge link.sck or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      addr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      rd_tgl_r <= 1'b0;
      wr_tgl_r <= 1'b0;
    end else begin
      if (new_rd & (st_r == ST_RDATA)) begin
        addr_r <= byte_in; // RL8
      end else if (byte_end && st_r == ST_ADDR) begin
        addr_r <= byte_in;
      end
      if (byte_end && st_r == ST_WDATA) begin
        wdata_r <= {wdata_r[23:0], byte_in}; // RL9
      end
      if (new_rd) begin
        rd_tgl_r <= ~rd_tgl_r;
      end
      if (new_wr) begin
        wr_tgl_r <= ~wr_tgl_r;
      end
    end
  end

  // miso byte selection; command addresses have no storage and read as zero
  wire [31:0] rd_word = is_cmd_addr ? 32'h0000_0000 : rd_data_r; // RL18
  wire fw_reply = (st_r == ST_WDATA) & (addr_r == ssp_pkg::ADDR_FW_QUERY); // RL14
  wire [7:0] rd_byte = ssp_pkg::byte_of(rd_word, dcnt_r); // RL6
  wire [7:0] fw_byte = ssp_pkg::byte_of(FW_REVISION, dcnt_r);
  wire [7:0] tx_load = (st_r == ST_RDATA) ? rd_byte : (fw_reply ? fw_byte : 8'h00); // RL10 RL20

  // falling edge: present next bit so it is stable at the master's rising edge
  always_ff @(negedge link.sck or posedge link_rst) begin
    if (link_rst) begin
      tx_r <= 8'h00;
    end else if (bit_cnt_r == 3'h0) begin
      tx_r <= tx_load; // RL2
    end else begin
      tx_r <= {tx_r[6:0], 1'b0};
    end
  end

  // drive miso only while selected; never start anything on our own
  assign link.miso_o = tx_r[7]; // RL1
  assign link.miso_oe = ~link.ss_n; // RL1

  // toggle synchronisers; only stage 1 and 2 are compared
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rd_sync_r <= 3'h0;
      wr_sync_r <= 3'h0;
    end else begin
      rd_sync_r <= {rd_sync_r[1:0], rd_tgl_r};
      wr_sync_r <= {wr_sync_r[1:0], wr_tgl_r};
    end
  end

  wire rd_evt = rd_sync_r[2] ^ rd_sync_r[1];
  wire wr_evt = wr_sync_r[2] ^ wr_sync_r[1];
  // addr_r and wdata_r are settled long before their toggle is seen here
  wire wr_zero = (wdata_r == 32'h0000_0000); // RL12
  wire wr_cmd = wr_evt & is_cmd_addr & wr_zero; // RL18
  wire wr_reg = wr_evt & ~is_cmd_addr; // RL9

  // request pulses and addresses for the user side
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reg_rd_req_out <= 1'b0;
      rd_cap_r <= 1'b0;
      reg_wr_out <= 1'b0;
      reg_wr_nv_out <= 1'b0;
      reg_addr_out <= 8'h00;
      reg_wr_data_out <= 32'h0000_0000;
    end else begin
      reg_rd_req_out <= rd_evt; // RL6
      rd_cap_r <= reg_rd_req_out;
      reg_wr_out <= wr_reg; // RL9
      if (rd_evt | wr_evt) begin
        reg_addr_out <= addr_r;
      end
      if (wr_reg) begin
        reg_wr_data_out <= wdata_r;
        reg_wr_nv_out <= (addr_r < ssp_pkg::ADDR_DATA_BASE); // RL16 RL17
      end
    end
  end

  // read data is held here, then sampled by the link at the next byte start
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rd_data_r <= 32'h0000_0000;
    end else if (rd_cap_r) begin
      rd_data_r <= reg_rd_data_in; // RL6
    end
  end

  // command pulses; no completion is reported back over the link, only the revision bytes of the query
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cmd_out <= 1'b0;
      cmd_code_out <= 8'h00;
      gyro_bias_zeroing_command_out <= 1'b0;
      firmware_version_query_out <= 1'b0;
    end else begin
      cmd_out <= wr_cmd; // RL13
      if (wr_cmd) begin
        cmd_code_out <= addr_r;
      end
      gyro_bias_zeroing_command_out <= wr_cmd & (addr_r == ssp_pkg::ADDR_GYRO_ZERO); // RL15
      firmware_version_query_out <= wr_cmd & (addr_r == ssp_pkg::ADDR_FW_QUERY); // RL14
    end
  end

endmodule // ssp_dev

// ==== src/ssp_if.sv ====
// spi link between the sensor register port and its master
// assumes miso is pulled high by the board while the device releases it
`timescale 1ns/10ps
interface ssp_if;
  logic sck;
  logic ss_n;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  wire miso;

  // device releases miso when deselected; the pull-up then wins
  assign miso = miso_oe ? miso_o : 1'b1;

  modport dev (input sck, input ss_n, input mosi, output miso_o, output miso_oe);
  modport mst (output sck, output ss_n, output mosi, input miso);
endinterface

// ==== src/ssp_mst.sv ====
// master end of the sensor spi register port; makes sck by dividing clk_in
// assumes one request at a time, taken while req_ready_out is high
`timescale 1ns/10ps
module ssp_mst #(
  parameter int SCK_HALF_CYC = ssp_pkg::SCK_HALF_CYC,
  parameter int T_SS_CYC = ssp_pkg::T_SS_CYC
) (
  // system
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // link
  ssp_if.mst link,
  // request
  input wire logic req_valid_in,
  output logic req_ready_out,
  input wire logic req_write_in,
  input wire logic [7:0] req_addr_in,
  input wire logic [31:0] req_wdata_in,
  input wire logic [3:0] req_count_in,
  // response
  output logic resp_valid_out,
  output logic [31:0] resp_data_out,
  output logic [7:0] resp_addr_out
);

  // refuse settings the timer or the link timing cannot serve
  // a divider faster than the link maximum, or a short select setup, is refused here
  if (SCK_HALF_CYC < 2 || SCK_HALF_CYC > 63 || T_SS_CYC < 1 || T_SS_CYC > 63 ||
      T_SS_CYC * ssp_pkg::CLK_PERIOD_NS < ssp_pkg::T_SS_NS ||
      2 * SCK_HALF_CYC * ssp_pkg::CLK_PERIOD_NS < ssp_pkg::SCK_MIN_PERIOD_NS ||
      2 * SCK_HALF_CYC * ssp_pkg::CLK_PERIOD_NS > ssp_pkg::SCK_MAX_PERIOD_NS) begin : g_chk // RL3
    $error("ssp_mst: unsupported timing parameters");
  end

  typedef enum logic [3:0] {
    M_IDLE = 4'b0001,
    M_SETUP = 4'b0010,
    M_XFER = 4'b0100,
    M_END = 4'b1000
  } ssp_mst_st_e;

  localparam logic [5:0] HALF_LOAD = 6'(SCK_HALF_CYC - 1);
  localparam logic [5:0] SS_LOAD = 6'(T_SS_CYC - 1);

  ssp_mst_st_e st_r;
  logic [5:0] cnt_r;
  logic sck_r;
  logic ss_n_r;
  logic [7:0] tx_r;
  logic [2:0] bit_cnt_r;
  logic [5:0] byte_r;
  logic [5:0] last_byte_r;
  logic wr_r;
  logic [7:0] base_addr_r;
  logic [31:0] wdata_r;
  logic [31:0] rx_r;
  logic [1:0] miso_s_r;

  // byte selection for the next transfer
  wire tick = (cnt_r == 6'h00);
  wire [5:0] nb = byte_r + 6'h01;
  wire [5:0] nb_off = nb - 6'h02;
  wire [5:0] cur_off = byte_r - 6'h02;
  wire [7:0] chain_addr = base_addr_r + {4'h0, nb_off[5:2]} + 8'h01;
  wire chain_slot = (nb[1:0] == 2'b01) & (nb != last_byte_r); // RL8
  wire [7:0] rd_tx = chain_slot ? chain_addr : 8'h00; // RL7
  wire [7:0] wr_tx = ssp_pkg::byte_of(wdata_r, nb_off[1:0]); // RL12
  wire [7:0] next_tx = (nb == 6'h01) ? base_addr_r : (wr_r ? wr_tx : rd_tx); // RL5
  wire word_done = (byte_r >= 6'h02) & (byte_r[1:0] == 2'b01);
  wire [3:0] cnt_eff = (req_count_in == 4'h0) ? 4'h1 : req_count_in;

  assign req_ready_out = (st_r == M_IDLE);
  assign link.sck = sck_r;
  assign link.ss_n = ss_n_r;
  assign link.mosi = tx_r[7];

  // miso comes from the other domain: two flops before use
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      miso_s_r <= 2'b11;
    end else begin
      miso_s_r <= {miso_s_r[0], link.miso};
    end
  end

  // frame sequencer and clock divider
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_r <= M_IDLE;
      cnt_r <= 6'h00;
      sck_r <= 1'b0;
      ss_n_r <= 1'b1;
      tx_r <= 8'h00;
      bit_cnt_r <= 3'h0;
      byte_r <= 6'h00;
      last_byte_r <= 6'h00;
      wr_r <= 1'b0;
      base_addr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      rx_r <= 32'h0000_0000;
      resp_valid_out <= 1'b0;
      resp_data_out <= 32'h0000_0000;
      resp_addr_out <= 8'h00;
    end else begin
      resp_valid_out <= 1'b0;
      cnt_r <= tick ? 6'h00 : cnt_r - 6'h01;
      unique case (st_r)
        M_IDLE: begin
          if (req_valid_in) begin
            st_r <= M_SETUP;
            ss_n_r <= 1'b0;
            cnt_r <= SS_LOAD;
            wr_r <= req_write_in;
            base_addr_r <= req_addr_in;
            wdata_r <= req_wdata_in;
            last_byte_r <= req_write_in ? 6'h05 : {cnt_eff, 2'b01}; // RL11
            tx_r <= req_write_in ? ssp_pkg::OP_WRITE : ssp_pkg::OP_READ; // RL5
            byte_r <= 6'h00;
            bit_cnt_r <= 3'h0;
          end
        end
        M_SETUP: begin
          if (tick) begin
            st_r <= M_XFER;
            cnt_r <= HALF_LOAD; // RL3
          end
        end
        M_XFER: begin
          if (tick) begin
            cnt_r <= HALF_LOAD; // RL3
            if (!sck_r) begin
              sck_r <= 1'b1;
              rx_r <= {rx_r[30:0], miso_s_r[1]}; // RL2
            end else begin
              sck_r <= 1'b0; // RL2
              bit_cnt_r <= bit_cnt_r + 3'h1;
              if (bit_cnt_r == 3'h7) begin
                if (word_done) begin
                  resp_valid_out <= 1'b1; // RL6
                  resp_data_out <= rx_r;
                  resp_addr_out <= base_addr_r + {4'h0, cur_off[5:2]};
                end
                if (byte_r == last_byte_r) begin
                  st_r <= M_END;
                end else begin
                  byte_r <= nb;
                  tx_r <= next_tx; // RL4
                end
              end else begin
                tx_r <= {tx_r[6:0], 1'b0}; // RL4
              end
            end
          end
        end
        M_END: begin
          if (tick) begin
            st_r <= M_IDLE;
            ss_n_r <= 1'b1;
            tx_r <= 8'h00;
          end
        end
        default: st_r <= M_IDLE;
      endcase
    end
  end

endmodule // ssp_mst

// ==== src/ssp_pkg.sv ====
// constants and helpers shared by both ends of the sensor spi register port
// assumes a 25 mhz system clock and a mode-0 spi link whose clock the master makes
// Function
// RL1: device is slave only, idle until selected
// RL2: clock idles low, sample on rising edge
// RL3: master keeps sck at or below maximum
// RL4: master changes mosi on falling edge
// RL5: frame opens with operation byte, then address
// RL6: read returns four register bytes, msb first
// RL7: master holds mosi low during read data
// RL8: next address in last byte chains reads
// RL9: write stores next four bytes to register
// RL10: device drives miso low during writes
// RL11: one register per write, no chaining
// RL12: command is write with four zero bytes
// RL13: commands give no completion indication
// RL14: revision query returns revision in data bytes
// RL15: gyro zeroing starts on zero write
// RL16: configuration space at zero, storable
// RL17: data space from 0x55, not storable
// RL18: command addresses from 0xaa, no storage
// RL19: deselect ends frame, resets byte position
// RL20: unknown operation ignored, zeros returned
package ssp_pkg;

  // operation codes
  localparam logic [7:0] OP_READ = 8'h00;
  localparam logic [7:0] OP_WRITE = 8'h01;

  // address spaces and command addresses
  localparam logic [7:0] ADDR_CFG_BASE = 8'h00;
  localparam logic [7:0] ADDR_DATA_BASE = 8'h55;
  localparam logic [7:0] ADDR_CMD_BASE = 8'haa;
  localparam logic [7:0] ADDR_FW_QUERY = 8'haa;
  localparam logic [7:0] ADDR_GYRO_ZERO = 8'hac;

  // arbitrary revision text, four characters
  localparam logic [31:0] FW_REVISION_DEFAULT = 32'h74_65_73_74;

  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int SCK_MAX_KHZ = 400;
  localparam int SCK_MIN_PERIOD_NS = 1000000 / SCK_MAX_KHZ;
  localparam int SCK_MAX_PERIOD_NS = 5000;
  localparam int SCK_HALF_CYC = (SCK_MIN_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
  localparam int T_SS_NS = 1000;
  localparam int T_SS_CYC = (T_SS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // byte i of a word, i = 0 is the most significant
  function automatic logic [7:0] byte_of(input logic [31:0] w, input logic [1:0] i);
    byte_of = w[{~i, 3'b000} +: 8];
  endfunction

endpackage

// ==== verification/ssp_checker.sv ====
// link assertions for the sensor spi register port
// assumes clk_in samples the link; the sck-side helpers clear while ss_n is high
`timescale 1ns/10ps
module ssp_checker #(
  parameter int SCK_HALF_CYC = 32,
  parameter int T_SS_CYC = 25,
  parameter logic [31:0] FW_REVISION = 32'h0
) (
  // system
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // link
  input wire logic sck,
  input wire logic ss_n,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe,
  input wire logic miso
);
  logic [9:0] bit_r;
  logic [15:0] hdr_r;
  logic wr_w;
  logic fw_w;
  logic [4:0] idx_w;
  logic rd_w;
  logic [9:0] rd_pos_w;

  // bit position and header bytes; saturates so long chained reads cannot wrap
  always_ff @(posedge sck or posedge ss_n) begin
    if (ss_n) begin
      bit_r <= 10'h000;
      hdr_r <= 16'h0000;
    end else begin
      bit_r <= (bit_r == 10'h3ff) ? bit_r : bit_r + 10'h001;
      hdr_r <= (bit_r < 10'h010) ? {hdr_r[14:0], mosi} : hdr_r;
    end
  end

  // decoded frame phase
  assign wr_w = hdr_r[15:8] == 8'h01 && bit_r >= 10'h010;
  assign fw_w = wr_w && hdr_r[7:0] == 8'haa && bit_r < 10'h030;
  assign idx_w = 5'(bit_r - 10'h010);
  // read data phase; a saturated count is left unjudged
  assign rd_w = hdr_r[15:8] == 8'h00 && bit_r >= 10'h010 && bit_r != 10'h3ff;
  assign rd_pos_w = bit_r - 10'h010;

  sequence s_setup;
    (!sck) throughout (##T_SS_CYC 1'b1);
  endsequence

  property p_release;
    @(posedge clk_in) disable iff (sys_rst_in) ss_n |-> !miso_oe && miso;
  endproperty
  a_release: assert property (p_release) else $error("miso driven while deselected");
  property p_idle_low;
    @(posedge clk_in) disable iff (sys_rst_in) ss_n |-> !sck;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("sck not low outside frame");
  property p_mosi_edge;
    @(posedge clk_in) disable iff (sys_rst_in) $changed(mosi) |-> $fell(sck) || ss_n || $fell(ss_n);
  endproperty
  a_mosi_edge: assert property (p_mosi_edge) else $error("mosi moved off a falling sck");
  property p_miso_edge;
    @(posedge clk_in) disable iff (sys_rst_in) !ss_n && !$past(ss_n) && $changed(miso_o) |-> $fell(sck);
  endproperty
  a_miso_edge: assert property (p_miso_edge) else $error("miso moved off a falling sck");
  property p_sck_high;
    @(posedge clk_in) disable iff (sys_rst_in) $rose(sck) |-> ##SCK_HALF_CYC $fell(sck);
  endproperty
  a_sck_high: assert property (p_sck_high) else $error("sck high phase wrong length");
  property p_setup;
    @(posedge clk_in) disable iff (sys_rst_in) $fell(ss_n) |-> s_setup;
  endproperty
  a_setup: assert property (p_setup) else $error("sck rose too soon after select");
  property p_hdr_quiet;
    @(posedge sck) disable iff (ss_n) bit_r < 10'h010 |-> !miso;
  endproperty
  a_hdr_quiet: assert property (p_hdr_quiet) else $error("miso high during header");
  property p_write_quiet;
    @(posedge sck) disable iff (ss_n) wr_w && !fw_w |-> !miso;
  endproperty
  a_write_quiet: assert property (p_write_quiet) else $error("miso high during write");
  property p_fw_rev;
    @(posedge sck) disable iff (ss_n) fw_w |-> miso == FW_REVISION[~idx_w];
  endproperty
  a_fw_rev: assert property (p_fw_rev) else $error("revision bit wrong on miso");
  // only the last byte of each read word may carry the next address
  property p_read_mosi;
    @(posedge sck) disable iff (ss_n) rd_w && rd_pos_w[4:3] != 2'b11 |-> !mosi;
  endproperty
  a_read_mosi: assert property (p_read_mosi) else $error("mosi high inside read data");
endmodule // ssp_checker

// ==== verification/tb.sv ====
// bench: master and device joined on one link, a second device driven by hand
// assumes 25 mhz clk_in; the hand link clock runs at 160 ns only inside frames
`timescale 1ns/10ps
module tb;
  localparam logic [31:0] FW_REV = 32'h6a6b6c6d; // arbitrary revision text
  logic clk_in, sys_rst_in, req_valid, req_ready, req_write, resp_valid;
  logic rd_req, wr, wr_nv, cmd, gyro, fw, b_rd_req, b_wr, b_cmd;
  logic [7:0] req_addr, resp_addr, addr, cmd_code, b_addr;
  logic [31:0] req_wdata, resp_data, rd_data, wr_data, b_wr_data;
  logic [3:0] req_count;
  logic [31:0] rsp_d [$];
  logic [7:0] rsp_a [$];
  int error_cnt, checks_done, cyc, wr_n, cmd_n, gyro_n, fw_n, b_wr_n, b_oth_n, rd_n;

  ssp_if link_a ();
  ssp_if link_b ();
  ssp_mst ssp_mst_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .link(link_a.mst), .req_valid_in(req_valid),
    .req_ready_out(req_ready), .req_write_in(req_write), .req_addr_in(req_addr), .req_wdata_in(req_wdata),
    .req_count_in(req_count), .resp_valid_out(resp_valid), .resp_data_out(resp_data), .resp_addr_out(resp_addr));
  ssp_dev #(.FW_REVISION(FW_REV)) ssp_dev_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .link(link_a.dev),
    .reg_rd_req_out(rd_req), .reg_rd_data_in(rd_data), .reg_wr_out(wr), .reg_wr_nv_out(wr_nv),
    .reg_wr_data_out(wr_data), .reg_addr_out(addr), .cmd_out(cmd), .cmd_code_out(cmd_code),
    .gyro_bias_zeroing_command_out(gyro), .firmware_version_query_out(fw));
  ssp_dev #(.FW_REVISION(FW_REV)) ssp_dev_inst_b (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .link(link_b.dev),
    .reg_rd_req_out(b_rd_req), .reg_rd_data_in(32'h00000000), .reg_wr_out(b_wr), .reg_wr_nv_out(),
    .reg_wr_data_out(b_wr_data), .reg_addr_out(b_addr), .cmd_out(b_cmd), .cmd_code_out(),
    .gyro_bias_zeroing_command_out(), .firmware_version_query_out());
  ssp_checker #(.SCK_HALF_CYC(ssp_pkg::SCK_HALF_CYC), .T_SS_CYC(ssp_pkg::T_SS_CYC), .FW_REVISION(FW_REV))
    ssp_checker_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .sck(link_a.sck), .ss_n(link_a.ss_n),
    .mosi(link_a.mosi), .miso_o(link_a.miso_o), .miso_oe(link_a.miso_oe), .miso(link_a.miso));

  // register contents seen by the device; held steady while the address stands
  function automatic logic [31:0] model(input logic [7:0] a);
    return {a, ~a, a ^ 8'h5a, 8'h3c};
  endfunction
  assign rd_data = model(addr);

  // clock, and pulse tallies plus response capture; sampled at the falling edge,
  // away from the rising edge that launches the pulses
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  always @(negedge clk_in) begin
    cyc++;
    if (rd_req) rd_n++;
    if (wr) wr_n++;
    if (cmd) cmd_n++;
    if (gyro) gyro_n++;
    if (fw) fw_n++;
    if (b_wr) b_wr_n++;
    if (b_cmd || b_rd_req) b_oth_n++;
    if (resp_valid) begin
      rsp_d.push_back(resp_data);
      rsp_a.push_back(resp_addr);
    end
    if (cyc == 60000) begin
      error_cnt++;
      test_done();
    end
  end

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // one master request, held until taken, then waits for the frame to close
  task automatic mst_xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] n);
    rsp_d = {};
    rsp_a = {};
    wr_n = 0;
    rd_n = 0;
    cmd_n = 0;
    gyro_n = 0;
    fw_n = 0;
    @(negedge clk_in);
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    req_count = n;
    // ready is looked at while settled, never in the step of the edge that moves it
    while (req_ready !== 1'b1) @(negedge clk_in);
    @(posedge clk_in);
    @(negedge clk_in);
    req_valid = 1'b0;
    repeat (4) @(negedge clk_in);
    while (req_ready !== 1'b1) @(negedge clk_in);
    repeat (8) @(negedge clk_in);
  endtask

  // hand-made frame on the second link; sck stands low outside it
  task automatic bb_frame(input logic [47:0] v, input int nb, output logic [47:0] r);
    r = '0;
    @(negedge clk_in);
    #13 link_b.ss_n = 1'b0;
    #1000;
    for (int i = 47; i > 47 - 8 * nb; i--) begin
      link_b.mosi = v[i];
      #80 r[i] = link_b.miso;
      link_b.sck = 1'b1;
      #80 link_b.sck = 1'b0;
    end
    #400 link_b.ss_n = 1'b1;
    link_b.mosi = ~link_b.mosi;
    #400;
  endtask

  task automatic t_write();
    logic [7:0] a [2] = '{8'h12, 8'h60};
    for (int i = 0; i < 2; i++) begin
      mst_xfer(1'b1, a[i], 32'ha5c30f81 ^ {4{a[i]}}, 4'h1);
      check(wr_n, 1);
      check(addr, a[i]);
      check(wr_data, 32'ha5c30f81 ^ {4{a[i]}});
      check(wr_nv, a[i] < 8'h55);
      check(rsp_d[0], 0);
    end
    $display("write test finished");
  endtask

  task automatic t_read();
    mst_xfer(1'b0, 8'h54, 0, 4'h3);
    check(rsp_d.size(), 3);
    check(rsp_a[0], 8'h54);
    foreach (rsp_d[i]) check(rsp_d[i], model(rsp_a[i]));
    foreach (rsp_a[i]) check(rsp_a[i], 8'h54 + i);
    // three words, plus the zero address sent in the last byte opens one more request
    check(rd_n, 4);
    mst_xfer(1'b0, 8'hab, 0, 4'h1);
    check(rsp_d[0], 0);
    check(wr_n + cmd_n, 0);
    $display("read test finished");
  endtask

  task automatic t_cmd();
    logic [7:0] a [4] = '{8'hac, 8'haa, 8'hac, 8'hab};
    logic [31:0] d [4] = '{0, 0, 32'h00000100, 0};
    for (int i = 0; i < 4; i++) begin
      mst_xfer(1'b1, a[i], d[i], 4'h1);
      check(cmd_n, d[i] == 0);
      check(gyro_n, a[i] == 8'hac && d[i] == 0);
      check(fw_n, a[i] == 8'haa);
      check(wr_n, 0);
      check(rsp_d[0], a[i] == 8'haa ? FW_REV : 0);
      if (d[i] == 0) check(cmd_code, a[i]);
    end
    $display("command test finished");
  endtask

  // bad operation byte, then an aborted write, then a whole write
  task automatic t_link_b();
    logic [47:0] r;
    check(link_b.miso, 1);
    bb_frame(48'h5a0100000000, 6, r);
    check(r, 0);
    bb_frame(48'h012011110000, 4, r);
    bb_frame(48'h0121cafef00d, 6, r);
    repeat (8) @(posedge clk_in);
    check(r, 0);
    check(b_wr_n, 1);
    check(b_addr, 8'h21);
    check(b_wr_data, 32'hcafef00d);
    check(b_oth_n, 0);
    $display("second link test finished");
  endtask

  initial begin
    sys_rst_in = 1'b1;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 8'h00;
    req_wdata = 32'h00000000;
    req_count = 4'h0;
    link_b.sck = 1'b0;
    link_b.ss_n = 1'b1;
    link_b.mosi = 1'b0;
    repeat (6) @(posedge clk_in);
    @(negedge clk_in);
    sys_rst_in = 1'b0;
    repeat (5) @(posedge clk_in);
    t_write();
    t_read();
    t_cmd();
    t_link_b();
    test_done();
  end
endmodule // tb
